/* File: pho_holdover.sv */
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/100ps
`include "pho_cfg.svh"

module pho_holdover
	import pho_pkg::*;
(
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RST_N,
	// register port
	input wire logic [7:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR_EN,
	input wire logic RD_EN,
	output logic [7:0] RDATA,
	// asynchronous pins
	input wire logic ALIGN_LOW_N,
	input wire logic LOCK_PIN_LEVEL,
	// phase detector side
	input wire logic FIRST_REFERENCE_EVT,
	input wire logic SECOND_REFERENCE_EVT,
	input wire logic PD_IN_LOCK_WIN,
	input wire logic PD_OUT_UNLOCK_WIN,
	input wire logic PD_UP,
	input wire logic PD_DN,
	// charge pump and divider
	output logic CP_UP,
	output logic CP_DN,
	output logic CP_HIZ,
	output logic FB_MAIN_CNT_RST,
	// lock outputs
	output logic DIGITAL_LOCK_FLAG,
	output logic WINDOW_HIGH_RANGE,
	output logic LOCK_PIN_OUT,
	output logic LOCK_PIN_OE_N,
	output logic LOCK_PIN_CUR_SRC,
	output logic REFERENCE_MONITOR_PIN_PIN,
	output logic STATUS_PIN
);

	function automatic logic [7:0] ld_need(input logic [1:0] code);
		case (code)
			2'h0: ld_need = `PHO_LD_CYC0;
			2'h1: ld_need = `PHO_LD_CYC1;
			2'h2: ld_need = `PHO_LD_CYC2;
			default: ld_need = `PHO_LD_CYC3;
		endcase
	endfunction : ld_need

	// software registers
	logic [7:0] stat_pin_r;
	logic [7:0] ld_cfg_r;
	logic [7:0] ld_pin_r;
	logic [7:0] mon_pin_r;
	logic [7:0] ref_ctl_r;
	logic [7:0] hold_r;
	logic [7:0] rdata_r;

	wire wr_stat = WR_EN && (ADDR == `PHO_OFF_STAT_PIN);
	wire wr_ldcfg = WR_EN && (ADDR == `PHO_OFF_LD_CFG);
	wire wr_ldpin = WR_EN && (ADDR == `PHO_OFF_LD_PIN);
	wire wr_mon = WR_EN && (ADDR == `PHO_OFF_MON_PIN);
	wire wr_ref = WR_EN && (ADDR == `PHO_OFF_REF_CTL);
	wire wr_hold = WR_EN && (ADDR == `PHO_OFF_HOLD);

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			stat_pin_r <= `PHO_RST_VAL;
			ld_cfg_r <= `PHO_RST_VAL;
			ld_pin_r <= `PHO_RST_VAL;
		end else begin
			if (wr_stat)
				stat_pin_r <= WDATA;
			if (wr_ldcfg)
				ld_cfg_r <= WDATA;
			if (wr_ldpin)
				ld_pin_r <= WDATA;
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			mon_pin_r <= `PHO_RST_VAL;
			ref_ctl_r <= `PHO_RST_VAL;
			hold_r <= `PHO_RST_VAL;
		end else begin
			if (wr_mon)
				mon_pin_r <= WDATA;
			if (wr_ref)
				ref_ctl_r <= WDATA;
			if (wr_hold)
				hold_r <= WDATA;
		end
	end

	// configuration decode
	wire hold_en = hold_r[`PHO_HOLD_EN_A] && hold_r[`PHO_HOLD_EN_B];
	wire manual = hold_r[`PHO_HOLD_EXT];
	wire cmp_en = hold_r[`PHO_HOLD_CMP];
	wire ld_dis = ld_cfg_r[`PHO_LD_DIS];
	wire [1:0] ld_code = ld_cfg_r[`PHO_LD_CNT_LO+1:`PHO_LD_CNT_LO];
	wire [5:0] ld_sel = ld_pin_r[5:0];
	wire [4:0] mon_sel = mon_pin_r[4:0];
	wire [5:0] st_sel = stat_pin_r[7:2];

	// selected reference path event
	wire first_reference_ok = FIRST_REFERENCE_EVT && ref_ctl_r[`PHO_FIRST_REFERENCE_BUF];
	wire second_reference_ok = SECOND_REFERENCE_EVT && ref_ctl_r[`PHO_SECOND_REFERENCE_BUF];
	wire ref_evt = ref_ctl_r[`PHO_REF_SEL] ? second_reference_ok : first_reference_ok;

	// pin synchronisers, change taken when stages 2 and 3 agree
	logic [2:0] align_s_r;
	logic [2:0] lock_s_r;
	logic align_f_r;
	logic lock_f_r;

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			align_s_r <= 3'h7;
			lock_s_r <= 3'h0;
		end else begin
			align_s_r <= {align_s_r[1:0], ALIGN_LOW_N};
			lock_s_r <= {lock_s_r[1:0], LOCK_PIN_LEVEL};
		end
	end

	wire align_agree = (align_s_r[2] == align_s_r[1]);
	wire lock_agree = (lock_s_r[2] == lock_s_r[1]);
	wire align_nxt = align_agree ? align_s_r[2] : align_f_r;
	wire lock_nxt = lock_agree ? lock_s_r[2] : lock_f_r;

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			align_f_r <= 1'b1;
			lock_f_r <= 1'b0;
		end else begin
			align_f_r <= align_nxt;
			lock_f_r <= lock_nxt;
		end
	end

	// edge, not level, starts manual holdover
	wire align_fall = align_f_r && !align_nxt;
	wire align_high = align_f_r;

	// disabled comparator reads as high
	wire lock_lvl = cmp_en ? lock_f_r : 1'b1;

	// digital lock detection on reference events
	logic [7:0] ld_cnt_r;
	logic [7:0] ld_cnt_nxt;
	logic dld_r;
	logic dld_nxt;

	wire [7:0] ld_inc = (ld_cnt_r == 8'hFF) ? 8'hFF : ld_cnt_r + 8'h01;

	always_comb begin
		ld_cnt_nxt = ld_cnt_r;
		dld_nxt = dld_r;
		if (ld_dis) begin
			ld_cnt_nxt = 8'h00;
			dld_nxt = 1'b0;
		end else if (ref_evt) begin
			if (PD_OUT_UNLOCK_WIN) begin
				ld_cnt_nxt = 8'h00;
				dld_nxt = 1'b0;
			end else if (PD_IN_LOCK_WIN) begin
				ld_cnt_nxt = ld_inc;
				if (ld_inc >= ld_need(ld_code))
					dld_nxt = 1'b1;
			end else begin
				ld_cnt_nxt = 8'h00;
			end
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ld_cnt_r <= 8'h00;
			dld_r <= 1'b0;
		end else begin
			ld_cnt_r <= ld_cnt_nxt;
			dld_r <= dld_nxt;
		end
	end

	assign DIGITAL_LOCK_FLAG = dld_r;
	assign WINDOW_HIGH_RANGE = !ld_cfg_r[`PHO_LD_WIN];

	// holdover state machine
	pho_state_t state_r;
	pho_state_t state_nxt;
	logic rst_pulse_nxt;
	logic rst_pulse_r;

	wire man_go = manual && align_fall;
	wire auto_go = !manual && !lock_lvl;
	wire release_ok = manual ? align_high : 1'b1;
	wire rearm_done = manual || lock_lvl;

	always_comb begin
		state_nxt = state_r;
		rst_pulse_nxt = 1'b0;
		if (!hold_en) begin
			state_nxt = PHO_IDLE;
		end else begin
			case (state_r)
				PHO_IDLE: begin
					if (man_go || auto_go)
						state_nxt = PHO_HOLD;
				end
				PHO_HOLD: begin
					// stays until a selected reference event, in manual mode with the align pin also high
					if (ref_evt && release_ok) begin
						rst_pulse_nxt = 1'b1;
						state_nxt = manual ? PHO_IDLE : PHO_REARM;
					end
				end
				PHO_REARM: begin
					if (rearm_done)
						state_nxt = PHO_IDLE;
				end
				default: state_nxt = PHO_IDLE;
			endcase
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_r <= PHO_IDLE;
			rst_pulse_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			rst_pulse_r <= rst_pulse_nxt;
		end
	end

	wire hiz_nxt = (state_nxt == PHO_HOLD);

	// pump drive blocked while high impedance
	logic cp_up_r;
	logic cp_dn_r;
	logic cp_hiz_r;

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			cp_up_r <= 1'b0;
			cp_dn_r <= 1'b0;
			cp_hiz_r <= 1'b0;
		end else begin
			cp_up_r <= PD_UP && !hiz_nxt;
			cp_dn_r <= PD_DN && !hiz_nxt;
			cp_hiz_r <= hiz_nxt;
		end
	end

	assign CP_UP = cp_up_r;
	assign CP_DN = cp_dn_r;
	assign CP_HIZ = cp_hiz_r;
	// prescaler untouched, main counter only
	assign FB_MAIN_CNT_RST = rst_pulse_r;

	// lock pin and monitor pin drive
	wire cs_mode = (ld_sel == `PHO_LDPIN_CUR_SRC);
	wire dld_mode = (ld_sel == `PHO_LDPIN_DLD);
	wire mon_val = (mon_sel == `PHO_MON_CMP_HI) ? lock_f_r :
		(mon_sel == `PHO_MON_CMP_LO) ? !lock_f_r : 1'b0;
	wire st_val = (st_sel == `PHO_STAT_CMP_HI) ? lock_f_r :
		(st_sel == `PHO_STAT_CMP_LO) ? !lock_f_r : 1'b0;

	logic ldp_out_r;
	logic ldp_oe_n_r;
	logic ldp_cs_r;
	logic mon_r;
	logic st_r;

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ldp_out_r <= 1'b0;
			ldp_oe_n_r <= 1'b1;
			ldp_cs_r <= 1'b0;
		end else begin
			ldp_out_r <= dld_mode && dld_r;
			ldp_oe_n_r <= cs_mode;
			ldp_cs_r <= cs_mode && dld_r;
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			mon_r <= 1'b0;
			st_r <= 1'b0;
		end else begin
			mon_r <= mon_val;
			st_r <= st_val;
		end
	end

	assign LOCK_PIN_OUT = ldp_out_r;
	assign LOCK_PIN_OE_N = ldp_oe_n_r;
	assign LOCK_PIN_CUR_SRC = ldp_cs_r;
	assign REFERENCE_MONITOR_PIN_PIN = mon_r;
	assign STATUS_PIN = st_r;

	// read side, one cycle after the strobe
	wire [7:0] status_val = {4'h0, (state_r == PHO_REARM),
		lock_lvl, cp_hiz_r, dld_r};
	wire [7:0] rd_mux =
		(ADDR == `PHO_OFF_STAT_PIN) ? stat_pin_r :
		(ADDR == `PHO_OFF_LD_CFG) ? ld_cfg_r :
		(ADDR == `PHO_OFF_LD_PIN) ? ld_pin_r :
		(ADDR == `PHO_OFF_MON_PIN) ? mon_pin_r :
		(ADDR == `PHO_OFF_REF_CTL) ? ref_ctl_r :
		(ADDR == `PHO_OFF_HOLD) ? hold_r :
		(ADDR == `PHO_OFF_STATUS) ? status_val : 8'h00;

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N)
			rdata_r <= 8'h00;
		else if (RD_EN)
			rdata_r <= rd_mux;
		else
			rdata_r <= 8'h00;
	end

	assign RDATA = rdata_r;

	// checks
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);

	sequence s_in_hold;
		CP_HIZ && hold_en && manual;
	endsequence

	sequence s_release;
		align_high && ref_evt;
	endsequence

	a_pump_quiet: assert property (
		CP_HIZ |-> !CP_UP && !CP_DN)
		else $error("pump driven in holdover");

	a_enable_gate: assert property (
		!hold_en |=> !CP_HIZ && !FB_MAIN_CNT_RST)
		else $error("holdover active while disabled");

	a_manual_entry: assert property (
		hold_en && manual && align_fall &&
		state_r == PHO_IDLE |=> CP_HIZ)
		else $error("manual edge missed");

	a_wait_ref: assert property (
		CP_HIZ && hold_en && !ref_evt ##1 hold_en |-> CP_HIZ)
		else $error("left holdover without reference");

	a_manual_exit: assert property (
		s_in_hold ##0 s_release ##1 hold_en |->
		!CP_HIZ && FB_MAIN_CNT_RST)
		else $error("manual release wrong");

	a_cnt_reset: assert property (
		FB_MAIN_CNT_RST |-> !CP_HIZ && $past(CP_HIZ))
		else $error("counter reset out of step");

	a_auto_entry: assert property (
		hold_en && state_r == PHO_IDLE && auto_go |=> CP_HIZ)
		else $error("lock loss missed");

	a_cmp_off: assert property (
		hold_en && !manual && !cmp_en && !CP_HIZ |=> !CP_HIZ)
		else $error("comparator off but holdover entered");

	a_rearm_block: assert property (
		state_r == PHO_REARM && !lock_lvl && !manual |=>
		!CP_HIZ)
		else $error("re-entered before charge");

	a_unlock_drop: assert property (
		ref_evt && PD_OUT_UNLOCK_WIN |=> !DIGITAL_LOCK_FLAG)
		else $error("lock kept after unlock");

	a_cur_src: assert property (
		cs_mode && dld_r && $stable(ld_sel) |=> LOCK_PIN_CUR_SRC)
		else $error("current source not routed");

endmodule : pho_holdover

/* File: pho_cfg.svh */
`ifndef PHO_CFG_SVH
`define PHO_CFG_SVH
`define PHO_OFF_STAT_PIN 8'h17
`define PHO_OFF_LD_CFG 8'h18
`define PHO_OFF_LD_PIN 8'h1A
`define PHO_OFF_MON_PIN 8'h1B
`define PHO_OFF_REF_CTL 8'h1C
`define PHO_OFF_HOLD 8'h1D
`define PHO_OFF_STATUS 8'h1F
`define PHO_RST_VAL 8'h00
`define PHO_HOLD_EN_A 0
`define PHO_HOLD_EXT 1
`define PHO_HOLD_EN_B 2
`define PHO_HOLD_CMP 3
`define PHO_LD_CNT_LO 5
`define PHO_LD_WIN 4
`define PHO_LD_DIS 3
`define PHO_FIRST_REFERENCE_BUF 1
`define PHO_SECOND_REFERENCE_BUF 2
`define PHO_REF_SEL 6
`define PHO_LDPIN_CUR_SRC 6'h04
`define PHO_LDPIN_DLD 6'h01
`define PHO_MON_CMP_HI 5'h0C
`define PHO_MON_CMP_LO 5'h1C
`define PHO_STAT_CMP_HI 6'h2C
`define PHO_STAT_CMP_LO 6'h3C
`define PHO_LD_CYC0 8'h05
`define PHO_LD_CYC1 8'h10
`define PHO_LD_CYC2 8'h40
`define PHO_LD_CYC3 8'hFF
`endif

/* File: pho_pkg.sv */
package pho_pkg;
	typedef enum logic [2:0] {
		PHO_IDLE = 3'b001,
		PHO_HOLD = 3'b010,
		PHO_REARM = 3'b100
	} pho_state_t;
endpackage : pho_pkg

/* File: tb_top.sv */
`timescale 1ns/100ps
module tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic aln = 1'b1;
	logic lvl = 1'b0;
	logic e1 = 1'b0;
	logic e2 = 1'b0;
	logic inw = 1'b0;
	logic outw = 1'b0;
	logic pu = 1'b0;
	logic pd = 1'b0;
	logic pu_q = 1'b0;
	logic pd_q = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [7:0] wd = 8'h00;
	logic [7:0] rdat;
	logic cu, cd, hiz, frst, flag, whr, lpo, loe_n, lcs, rmon, stat;
	int n_fail = 0;
	int comparisons = 0;
	int mdl [256] = '{default: 0};
	int need [4] = '{5, 16, 64, 255};

	always #20 clk = ~clk;

	// random pump requests keep the pass-through path busy
	always @(posedge clk) begin
		pu_q <= pu;
		pd_q <= pd;
		pu <= 1'($urandom);
		pd <= 1'($urandom);
	end

	pho_holdover i_dut (
		.REF_CLK(clk), .RST_N(rst_n), .ADDR(adr), .WDATA(wd),
		.WR_EN(wr), .RD_EN(rd), .RDATA(rdat), .ALIGN_LOW_N(aln),
		.LOCK_PIN_LEVEL(lvl), .FIRST_REFERENCE_EVT(e1), .SECOND_REFERENCE_EVT(e2),
		.PD_IN_LOCK_WIN(inw), .PD_OUT_UNLOCK_WIN(outw), .PD_UP(pu),
		.PD_DN(pd), .CP_UP(cu), .CP_DN(cd), .CP_HIZ(hiz),
		.FB_MAIN_CNT_RST(frst), .DIGITAL_LOCK_FLAG(flag),
		.WINDOW_HIGH_RANGE(whr), .LOCK_PIN_OUT(lpo),
		.LOCK_PIN_OE_N(loe_n), .LOCK_PIN_CUR_SRC(lcs),
		.REFERENCE_MONITOR_PIN_PIN(rmon), .STATUS_PIN(stat)
	);

	task end_sim;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_sim

	task chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	task wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		adr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		if (a >= 8'h17 && a <= 8'h1D && a != 8'h19)
			mdl[a] = d;
	endtask : wr_reg

	task rd_reg(input logic [7:0] a);
		@(posedge clk);
		adr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdat, 8'(mdl[a]));
	endtask : rd_reg

	// bounded wait for the pump state, then one compare
	task wait_hiz(input logic v, input int lim);
		for (int k = 0; k < lim && hiz !== v; k++)
			@(posedge clk) #1;
		chk(hiz, v);
		if (hiz !== v)
			end_sim;
	endtask : wait_hiz

	task steady(input logic v, input int n);
		repeat (n) begin
			@(posedge clk) #1;
			chk(hiz, v);
			if (v)
				chk({cu, cd}, 2'b00);
			else
				chk({cu, cd}, {pu_q, pd_q});
		end
	endtask : steady

	task ev(input logic two, input logic i, input logic o);
		@(posedge clk);
		e1 <= ~two;
		e2 <= two;
		inw <= i;
		outw <= o;
		@(posedge clk);
		e1 <= 1'b0;
		e2 <= 1'b0;
		inw <= 1'b0;
		outw <= 1'b0;
		#1;
	endtask : ev

	initial begin
		#2000000;
		n_fail++;
		$display("ERROR %0t run limit %h %h", $time, 1'b0, 1'b1);
		end_sim;
	end

	initial begin
		void'($urandom(32'he1a4d9e6));
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk({hiz, frst, loe_n}, 3'b001);
		for (int a = 8'h17; a <= 8'h1D; a++)
			wr_reg(8'(a), 8'($urandom));
		for (int a = 8'h17; a <= 8'h1D; a++)
			rd_reg(8'(a));
		rd_reg(8'h30);
		for (int a = 8'h17; a <= 8'h1D; a++)
			wr_reg(8'(a), 8'h00);
		wr_reg(8'h18, 8'h10);
		tick(1);
		chk(whr, 1'b0);
		wr_reg(8'h18, 8'h00);
		tick(1);
		chk(whr, 1'b1);
		wr_reg(8'h1C, 8'h02);
		// manual mode, first with the enables clear
		wr_reg(8'h1D, 8'h02);
		@(posedge clk) aln <= 1'b0;
		steady(1'b0, 8);
		@(posedge clk) aln <= 1'b1;
		tick(6);
		wr_reg(8'h1D, 8'h07);
		@(posedge clk) aln <= 1'b0;
		wait_hiz(1'b1, 8);
		@(posedge clk) aln <= 1'b1;
		steady(1'b1, 8);
		ev(1'b0, 1'b0, 1'b0);
		chk({hiz, frst}, 2'b01);
		tick(1);
		chk(frst, 1'b0);
		// automatic mode
		wr_reg(8'h1A, 8'h04);
		wr_reg(8'h1D, 8'h05);
		steady(1'b0, 8);
		wr_reg(8'h1D, 8'h0D);
		wait_hiz(1'b1, 8);
		ev(1'b0, 1'b0, 1'b0);
		chk({hiz, frst}, 2'b01);
		steady(1'b0, 8);
		wr_reg(8'h1F, 8'hFF);
		mdl[8'h1F] = 8'h08;
		rd_reg(8'h1F);
		@(posedge clk) lvl <= 1'b1;
		tick(6);
		@(posedge clk) lvl <= 1'b0;
		wait_hiz(1'b1, 8);
		mdl[8'h1F] = 8'h02;
		rd_reg(8'h1F);
		wr_reg(8'h1C, 8'h44);
		ev(1'b0, 1'b0, 1'b0);
		chk(hiz, 1'b1);
		ev(1'b1, 1'b0, 1'b0);
		chk({hiz, frst}, 2'b01);
		wr_reg(8'h1D, 8'h00);
		wr_reg(8'h1C, 8'h02);
		// lock detect for every counter code
		for (int c = 0; c < 4; c++) begin
			wr_reg(8'h18, 8'(c << 5));
			ev(1'b0, 1'b0, 1'b1);
			tick(1);
			chk(flag, 1'b0);
			repeat (need[c] - 1) ev(1'b0, 1'b1, 1'b0);
			tick(2);
			chk(flag, 1'b0);
			ev(1'b0, 1'b1, 1'b0);
			tick(1);
			chk(flag, 1'b1);
		end
		wr_reg(8'h1A, 8'h04);
		tick(2);
		chk({lcs, loe_n}, 2'b11);
		wr_reg(8'h1A, 8'h01);
		tick(2);
		chk({lpo, loe_n}, 2'b10);
		@(posedge clk) lvl <= 1'b1;
		wr_reg(8'h1B, 8'h0C);
		wr_reg(8'h17, 8'hB0);
		tick(5);
		chk({rmon, stat}, 2'b11);
		wr_reg(8'h1B, 8'h1C);
		wr_reg(8'h17, 8'hF0);
		tick(2);
		chk({rmon, stat}, 2'b00);
		@(posedge clk) lvl <= 1'b0;
		tick(6);
		chk({rmon, stat}, 2'b11);
		wr_reg(8'h18, 8'h08);
		tick(1);
		chk(flag, 1'b0);
		end_sim;
	end
endmodule : tb_top
